/* src/mcalu_alu.sv */
`default_nettype none
module mcalu_alu (
   // Datapath link
   mcalu_alu_if.alu u
);
   import mcalu_pkg::*;

   logic sub;
   logic cin;
   logic [7:0] bop;
   logic [7:0] mask;
   logic [8:0] sum;
   logic [4:0] nib;
   logic [8:0] t_lo;
   logic [8:0] t_hi;

   function automatic logic is_zero(input logic [7:0] v);
      return v == 8'h00;
   endfunction

   always_comb begin
      sub = (u.op == OP_SUB) || (u.op == OP_MINUS_WITH_WRAP);
      // Subtraction is a plus the inverted operand; carry set means no borrow.
      bop = sub ? ~u.b : u.b;
      cin = (u.op == OP_ADD) ? 1'b0 : ((u.op == OP_SUB) ? 1'b1 : u.flags_in.c);
      sum = {1'b0, u.a} + {1'b0, bop} + {8'h00, cin};
      nib = {1'b0, u.a[3:0]} + {1'b0, bop[3:0]} + {4'h0, cin};
      mask = 8'h01 << u.bitsel;
      t_lo = (u.a[3:0] > 4'h9 || u.flags_in.ac) ? {1'b0, u.a} + 9'h006 : {1'b0, u.a};
      t_hi = (t_lo[7:4] > 4'h9 || t_lo[8] || u.flags_in.c) ? t_lo + 9'h060 : t_lo;
      u.res = u.b;
      u.flags_out = u.flags_in;
      u.skip = 1'b0;
      unique case (u.op)
         OP_ADD, OP_ADC, OP_SUB, OP_MINUS_WITH_WRAP: begin
            u.res = sum[7:0];
            u.flags_out.z = is_zero(sum[7:0]);
            u.flags_out.c = sum[8];
            u.flags_out.ac = nib[4];
            u.flags_out.ov = (u.a[7] == bop[7]) && (sum[7] != u.a[7]);
            u.flags_out.sc = sum[7] ^ ((u.a[7] == bop[7]) && (sum[7] != u.a[7]));
            if (u.op == OP_SUB) begin
               u.flags_out.cz = is_zero(sum[7:0]);
            end else if (u.op == OP_MINUS_WITH_WRAP) begin
               u.flags_out.cz = is_zero(sum[7:0]) && u.flags_in.cz;
            end
         end
         OP_BCD_FIXUP: begin
            u.res = t_hi[7:0];
            u.flags_out.c = u.flags_in.c | t_lo[8] | t_hi[8];
         end
         OP_AND, OP_OR, OP_XOR: begin
            u.res = (u.op == OP_AND) ? (u.a & u.b) :
                    ((u.op == OP_OR) ? (u.a | u.b) : (u.a ^ u.b));
            u.flags_out.z = is_zero(u.res);
         end
         OP_INVERT: begin
            u.res = ~u.b;
            u.flags_out.z = is_zero(~u.b);
         end
         OP_INC, OP_DEC: begin
            u.res = (u.op == OP_INC) ? u.b + 8'h01 : u.b - 8'h01;
            u.flags_out.z = is_zero(u.res);
         end
         OP_RIGHT_ROTATE: u.res = {u.b[0], u.b[7:1]};
         OP_LEFT_ROTATE: u.res = {u.b[6:0], u.b[7]};
         OP_RIGHT_ROTATE_THROUGH_WRAP: begin
            u.res = {u.flags_in.c, u.b[7:1]};
            u.flags_out.c = u.b[0];
         end
         OP_LEFT_ROTATE_THROUGH_WRAP: begin
            u.res = {u.b[6:0], u.flags_in.c};
            u.flags_out.c = u.b[7];
         end
         OP_BIT_CLEAR: u.res = u.b & ~mask;
         OP_BIT_SET: u.res = u.b | mask;
         OP_SKIP_ZERO: u.skip = is_zero(u.b);
         OP_SKIP_NONZERO: u.skip = !is_zero(u.b);
         OP_SKIP_BIT_ZERO: u.skip = !u.b[u.bitsel];
         OP_SKIP_BIT_SET: u.skip = u.b[u.bitsel];
         OP_SKIP_INC_ZERO: begin
            u.res = u.b + 8'h01;
            u.skip = is_zero(u.b + 8'h01);
         end
         OP_SKIP_DEC_ZERO: begin
            u.res = u.b - 8'h01;
            u.skip = is_zero(u.b - 8'h01);
         end
         OP_NOP, OP_MOVE, OP_GOTO, OP_CALL, OP_SUBROUTINE_EXIT,
         OP_SUBROUTINE_EXIT_IMM, OP_TABLE_READ: u.res = u.b;
      endcase
   end
endmodule
`default_nettype wire

/* src/mcalu_alu_if.sv */
`default_nettype none
interface mcalu_alu_if;
   import mcalu_pkg::*;
   mcalu_op_t op;
   logic [7:0] a;
   logic [7:0] b;
   logic [2:0] bitsel;
   mcalu_flags_t flags_in;
   logic [7:0] res;
   mcalu_flags_t flags_out;
   logic skip;
   modport core (output op, a, b, bitsel, flags_in, input res, flags_out, skip);
   modport alu (input op, a, b, bitsel, flags_in, output res, flags_out, skip);
endinterface
`default_nettype wire

/* src/mcalu_consts.svh */
`ifndef MCALU_CONSTS_SVH
`define MCALU_CONSTS_SVH

// System clock period in nanoseconds.
`define MCALU_CLK_PERIOD_NS 100
// System clocks in one instruction cycle.
`define MCALU_INSTR_CLKS 4
// Program counter and instruction word widths.
`define MCALU_PC_W 12
`define MCALU_IW_W 20
// Return address store depth.
`define MCALU_STACK_DEPTH 8
// Instruction word fields.
`define MCALU_F_OP_HI 19
`define MCALU_F_OP_LO 14
`define MCALU_F_TO_MEM 13
`define MCALU_F_USE_IMM 12
`define MCALU_F_BIT_HI 10
`define MCALU_F_BIT_LO 8
`define MCALU_F_ARG_HI 7
`define MCALU_F_ARG_LO 0
// Data memory address that mirrors the program counter low byte.
`define MCALU_PROGRAM_COUNTER_LOW_BYTE_ADDR 8'h06
// Program memory page that holds constant tables.
`define MCALU_TABLE_PAGE 4'hF
// Reset values.
`define MCALU_PC_RESET 12'h000
`define MCALU_ACC_RESET 8'h00

`endif

/* src/mcalu_core.sv */
// Operation
// - Move copies memory to working register, register to memory, or immediate in.
// - Addition carries out above 255; subtraction borrows below 0.
// - Plain add forms take one cycle and update five arithmetic flags.
// - Add with carry adds the carry flag in, same five flags.
// - Subtract from working register updates five flags plus zero-with-borrow.
// - Subtract with carry uses carry as borrow input, updates six flags.
// - Decimal adjust fixes working register, writes memory, touches only carry.
// - AND, OR, XOR combine register with operand and touch only zero.
// - Complement inverts memory byte into memory or register, only zero.
// - Increment and decrement change by one, only zero flag changes.
// - Simple rotates wrap the shifted-out bit around, no flag changes.
// - Rotates through carry are nine-bit rotations, only carry changes.
// - Bit set and clear force one bit 0 to 7, others kept.
// - Bit operations perform their read-modify-write internally.
// - Jump loads the program counter and keeps no return address.
// - Call saves the next address; return resumes there.
// - Skips test a byte or bit and maybe skip the next instruction.
// - Table read fetches constant program memory data into the data path.
// - Data accesses reach only data memory sector 0.
// - An instruction cycle is four clocks; branches and tables take two.
// - A skip takes two cycles when taken, one otherwise.
// - Writing the program counter low byte takes two cycles, as a jump.
`include "mcalu_consts.svh"
`default_nettype none
module mcalu_core (
   // Clock, reset and enable
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   // Program memory
   output logic [`MCALU_PC_W-1:0] prog_addr,
   input wire logic [`MCALU_IW_W-1:0] prog_data,
   // Data memory, sector 0
   output logic [7:0] dm_addr,
   output logic [7:0] dm_wdata,
   output logic dm_we,
   input wire logic [7:0] dm_rdata,
   // Datapath state
   output logic [7:0] working_register,
   output logic [7:0] table_high,
   output logic [`MCALU_PC_W-1:0] program_counter,
   output logic zero_bit,
   output logic carry_bit,
   output logic nibble_wrap_bit,
   output logic signed_range_exceeded_bit,
   output logic true_sign_bit,
   output logic zero_with_borrow_bit
);
   import mcalu_pkg::*;

   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic [1:0] rst_sync_reg;
   logic rst_n;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_reg[1];

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [1:0] phase_reg;
   mcalu_state_t state_reg;
   mcalu_state_t state_next;
   logic [`MCALU_IW_W-1:0] instr_reg;
   logic [`MCALU_IW_W-1:0] table_word_reg;
   logic [7:0] mem_reg;
   logic [7:0] acc_reg;
   mcalu_flags_t flags_reg;
   logic [`MCALU_PC_W-1:0] pc_reg;
   logic [`MCALU_PC_W-1:0] pc_next;
   logic [`MCALU_PC_W-1:0] prog_addr_reg;
   logic [`MCALU_PC_W-1:0] stack_top;
   logic [7:0] dm_addr_reg;
   logic [7:0] dm_wdata_reg;
   logic dm_we_reg;
   logic [7:0] table_high_reg;

   mcalu_op_t op;
   logic to_mem;
   logic use_imm;
   logic [2:0] bitsel;
   logic [7:0] arg;
   logic [7:0] b_val;
   logic [7:0] wdata;
   logic exec;
   logic wr_acc;
   logic wr_mem;
   logic branch;
   logic push;
   logic pop;
   logic pcl_hit;

   function automatic mcalu_op_t decode_op(input logic [5:0] code);
      if (code > 6'(OP_TABLE_READ)) begin
         return OP_NOP;
      end
      return mcalu_op_t'(code);
   endfunction

   assign op = decode_op(instr_reg[`MCALU_F_OP_HI:`MCALU_F_OP_LO]);
   assign to_mem = instr_reg[`MCALU_F_TO_MEM];
   assign use_imm = instr_reg[`MCALU_F_USE_IMM];
   assign bitsel = instr_reg[`MCALU_F_BIT_HI:`MCALU_F_BIT_LO];
   assign arg = instr_reg[`MCALU_F_ARG_HI:`MCALU_F_ARG_LO];
   assign b_val = use_imm ? arg : mem_reg;
   // Execution happens on the third clock of the instruction cycle.
   assign exec = ce && (phase_reg == 2'h2) && (state_reg == ST_EXEC);

   // ---------------------------------------------------------------
   // Arithmetic unit and return address store
   // ---------------------------------------------------------------
   mcalu_alu_if alu_link ();

   assign alu_link.op = op;
   assign alu_link.a = acc_reg;
   assign alu_link.b = b_val;
   assign alu_link.bitsel = bitsel;
   assign alu_link.flags_in = flags_reg;

   mcalu_alu u_alu (
      .u (alu_link.alu)
   );

   mcalu_stack u_stack (
      .clk (clk),
      .rst_n (rst_n),
      .ce (ce),
      .push (push),
      .pop (pop),
      .push_data (pc_reg + `MCALU_PC_W'(1)),
      .top (stack_top)
   );

   // A plain store puts the working register out; all else stores the unit's result.
   assign wdata = (op == OP_MOVE) ? acc_reg : alu_link.res;
   assign pcl_hit = (dm_addr_reg == `MCALU_PROGRAM_COUNTER_LOW_BYTE_ADDR);

   // ---------------------------------------------------------------
   // Instruction decision
   // ---------------------------------------------------------------
   always_comb begin
      wr_acc = 1'b0;
      wr_mem = 1'b0;
      branch = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      pc_next = pc_reg + `MCALU_PC_W'(1);
      state_next = ST_EXEC;
      unique case (op)
         OP_NOP, OP_SKIP_NONZERO, OP_SKIP_BIT_ZERO, OP_SKIP_BIT_SET: begin
         end
         OP_MOVE, OP_ADD, OP_ADC, OP_SUB, OP_MINUS_WITH_WRAP, OP_AND, OP_OR,
         OP_XOR, OP_INVERT, OP_INC, OP_DEC, OP_RIGHT_ROTATE, OP_LEFT_ROTATE,
         OP_RIGHT_ROTATE_THROUGH_WRAP, OP_LEFT_ROTATE_THROUGH_WRAP,
         OP_SKIP_INC_ZERO, OP_SKIP_DEC_ZERO: begin
            wr_mem = to_mem;
            wr_acc = !to_mem;
         end
         OP_BCD_FIXUP, OP_BIT_CLEAR, OP_BIT_SET: begin
            wr_mem = 1'b1;
         end
         OP_SKIP_ZERO: begin
            wr_acc = !to_mem;
         end
         OP_GOTO: begin
            branch = 1'b1;
            pc_next = instr_reg[`MCALU_PC_W-1:0];
         end
         OP_CALL: begin
            branch = 1'b1;
            push = exec;
            pc_next = instr_reg[`MCALU_PC_W-1:0];
         end
         OP_SUBROUTINE_EXIT, OP_SUBROUTINE_EXIT_IMM: begin
            branch = 1'b1;
            pop = exec;
            wr_acc = (op == OP_SUBROUTINE_EXIT_IMM);
            pc_next = stack_top;
         end
         OP_TABLE_READ: begin
            state_next = ST_TABLE;
         end
      endcase
      if (alu_link.skip) begin
         pc_next = pc_reg + `MCALU_PC_W'(2);
         state_next = ST_FLUSH;
      end
      if (wr_mem && pcl_hit) begin
         pc_next = {pc_reg[`MCALU_PC_W-1:8], wdata};
         state_next = ST_FLUSH;
      end
      if (branch) begin
         state_next = ST_FLUSH;
      end
   end

   // ---------------------------------------------------------------
   // Cycle phase and sequence state
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_reg <= 2'h0;
      end else if (ce) begin
         phase_reg <= phase_reg + 2'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_EXEC;
      end else if (ce && phase_reg == 2'h2) begin
         state_reg <= (state_reg == ST_EXEC) ? state_next : ST_EXEC;
      end
   end

   // ---------------------------------------------------------------
   // Fetch and operand read
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prog_addr_reg <= `MCALU_PC_RESET;
      end else if (ce && phase_reg == 2'h3) begin
         prog_addr_reg <= (state_reg == ST_TABLE) ?
                          {`MCALU_TABLE_PAGE, acc_reg} : pc_reg;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         instr_reg <= '0;
         table_word_reg <= '0;
         dm_addr_reg <= 8'h00;
      end else if (ce && phase_reg == 2'h0) begin
         if (state_reg == ST_TABLE) begin
            table_word_reg <= prog_data;
         end else begin
            instr_reg <= prog_data;
            dm_addr_reg <= prog_data[`MCALU_F_ARG_HI:`MCALU_F_ARG_LO];
         end
      end
   end

   // The low byte of the program counter reads back through its memory address.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_reg <= 8'h00;
      end else if (ce && phase_reg == 2'h1) begin
         mem_reg <= pcl_hit ? pc_reg[7:0] : dm_rdata;
      end
   end

   // ---------------------------------------------------------------
   // Execution results
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_reg <= `MCALU_ACC_RESET;
      end else if (exec && wr_acc) begin
         acc_reg <= alu_link.res;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_reg <= '0;
      end else if (exec) begin
         flags_reg <= alu_link.flags_out;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_reg <= `MCALU_PC_RESET;
      end else if (exec) begin
         pc_reg <= pc_next;
      end
   end

   // The write strobe is one clock wide, in the last clock of the cycle.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dm_we_reg <= 1'b0;
         dm_wdata_reg <= 8'h00;
         table_high_reg <= 8'h00;
      end else if (ce) begin
         dm_we_reg <= 1'b0;
         if (exec && wr_mem) begin
            dm_we_reg <= 1'b1;
            dm_wdata_reg <= wdata;
         end else if (phase_reg == 2'h2 && state_reg == ST_TABLE) begin
            dm_we_reg <= 1'b1;
            dm_wdata_reg <= table_word_reg[7:0];
            table_high_reg <= table_word_reg[15:8];
         end
      end
   end

   assign prog_addr = prog_addr_reg;
   assign dm_addr = dm_addr_reg;
   assign dm_wdata = dm_wdata_reg;
   assign dm_we = dm_we_reg;
   assign working_register = acc_reg;
   assign table_high = table_high_reg;
   assign program_counter = pc_reg;
   assign zero_bit = flags_reg.z;
   assign carry_bit = flags_reg.c;
   assign nibble_wrap_bit = flags_reg.ac;
   assign signed_range_exceeded_bit = flags_reg.ov;
   assign true_sign_bit = flags_reg.sc;
   assign zero_with_borrow_bit = flags_reg.cz;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   logic [8:0] chk_sum;

   assign chk_sum = {1'b0, acc_reg} + {1'b0, b_val};

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_move_load: assert property (
      exec && op == OP_MOVE && !to_mem |=> acc_reg == $past(b_val))
      else $error("move did not load the working register");
   a_move_store: assert property (
      exec && op == OP_MOVE && to_mem |=> dm_we_reg && dm_wdata_reg == $past(acc_reg))
      else $error("move did not store the working register");
   a_add_carry: assert property (
      exec && op == OP_ADD |=> flags_reg.c == $past(chk_sum[8]) && acc_reg == $past(chk_sum[7:0]))
      else $error("add carry or sum wrong");
   a_sub_borrow: assert property (
      exec && op == OP_SUB |=> flags_reg.c == ($past(acc_reg) >= $past(b_val)))
      else $error("subtract borrow wrong");
   a_logic_zero: assert property (
      exec && op inside {OP_AND, OP_OR, OP_XOR}
      |=> flags_reg.z == ($past(alu_link.res) == 8'h00) && flags_reg.c == $past(flags_reg.c))
      else $error("logic operation flags wrong");
   a_rotate_flags: assert property (
      exec && op inside {OP_RIGHT_ROTATE, OP_LEFT_ROTATE} |=> flags_reg == $past(flags_reg))
      else $error("simple rotate changed a flag");
   a_bit_set_keep: assert property (
      exec && op == OP_BIT_SET
      |=> dm_we_reg && dm_wdata_reg == ($past(mem_reg) | (8'h01 << $past(bitsel))))
      else $error("bit set result wrong");
   a_goto_target: assert property (
      exec && op == OP_GOTO
      |=> pc_reg == $past(instr_reg[`MCALU_PC_W-1:0]) && state_reg == ST_FLUSH)
      else $error("jump target or timing wrong");
   a_call_save: assert property (
      exec && op == OP_CALL |=> stack_top == $past(pc_reg) + `MCALU_PC_W'(1))
      else $error("call saved a wrong address");
   a_skip_cycle: assert property (
      exec && alu_link.skip |=> state_reg == ST_FLUSH && pc_reg == $past(pc_reg) + `MCALU_PC_W'(2))
      else $error("taken skip not two cycles");
   a_pcl_jump: assert property (
      exec && wr_mem && pcl_hit |=> state_reg == ST_FLUSH && pc_reg[7:0] == $past(wdata))
      else $error("program counter low write not a jump");
   a_phase_step: assert property (
      ce && state_reg == ST_FLUSH && phase_reg == 2'h2 |=> state_reg == ST_EXEC && phase_reg == 2'h3)
      else $error("cycle sequence wrong");
endmodule
`default_nettype wire

/* src/mcalu_pkg.sv */
`default_nettype none
package mcalu_pkg;
   typedef enum logic [5:0] {
      OP_NOP, OP_MOVE, OP_ADD, OP_ADC, OP_SUB, OP_MINUS_WITH_WRAP, OP_BCD_FIXUP,
      OP_AND, OP_OR, OP_XOR, OP_INVERT, OP_INC, OP_DEC, OP_RIGHT_ROTATE,
      OP_LEFT_ROTATE, OP_RIGHT_ROTATE_THROUGH_WRAP, OP_LEFT_ROTATE_THROUGH_WRAP,
      OP_BIT_CLEAR, OP_BIT_SET, OP_SKIP_ZERO, OP_SKIP_NONZERO, OP_SKIP_BIT_ZERO,
      OP_SKIP_BIT_SET, OP_SKIP_INC_ZERO, OP_SKIP_DEC_ZERO, OP_GOTO, OP_CALL,
      OP_SUBROUTINE_EXIT, OP_SUBROUTINE_EXIT_IMM, OP_TABLE_READ
   } mcalu_op_t;

   typedef enum logic [1:0] {ST_EXEC, ST_FLUSH, ST_TABLE} mcalu_state_t;

   typedef struct packed {
      logic z;
      logic c;
      logic ac;
      logic ov;
      logic sc;
      logic cz;
   } mcalu_flags_t;
endpackage
`default_nettype wire

/* src/mcalu_stack.sv */
`include "mcalu_consts.svh"
`default_nettype none
module mcalu_stack (
   // Clock, reset and enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Push and pop
   input wire logic push,
   input wire logic pop,
   input wire logic [`MCALU_PC_W-1:0] push_data,
   output logic [`MCALU_PC_W-1:0] top
);
   logic [`MCALU_PC_W-1:0] slot_reg [`MCALU_STACK_DEPTH];
   logic [2:0] ptr_reg;

   // The store is circular: a ninth push overwrites the oldest entry.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr_reg <= 3'h0;
      end else if (ce && push) begin
         ptr_reg <= ptr_reg + 3'h1;
      end else if (ce && pop) begin
         ptr_reg <= ptr_reg - 3'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (ce && push) begin
         slot_reg[ptr_reg] <= push_data;
      end
   end

   assign top = slot_reg[ptr_reg - 3'h1];
endmodule
`default_nettype wire

/* testbench/mcalu_core_test.sv */
`include "mcalu_consts.svh"
`default_nettype none
module mcalu_core_test;
   import mcalu_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, reset_n, ce, dm_we, z, c, ac, ov, sc, cz;
   logic [11:0] prog_addr, program_counter;
   logic [19:0] prog_data;
   logic [7:0] dm_addr, dm_wdata, dm_rdata, acc, tbh;
   int err_total = 0;
   int checks_done = 0;
   int cyc = 0;
   logic [7:0] exp4 [0:11] = '{8'h14, 8'hBE, 8'hAA, 8'h69, 8'h97, 8'h95, 8'h4B, 8'h2D,
                              8'h97, 8'h16, 8'h4B, 8'h2C};
   mcalu_op_t ops4 [0:11] = '{OP_AND, OP_OR, OP_XOR, OP_INVERT, OP_INC, OP_DEC,
      OP_RIGHT_ROTATE, OP_LEFT_ROTATE, OP_BIT_SET, OP_BIT_CLEAR,
      OP_RIGHT_ROTATE_THROUGH_WRAP, OP_LEFT_ROTATE_THROUGH_WRAP};
   mcalu_core i_dut (.clk(clk), .reset_n(reset_n), .ce(ce), .prog_addr(prog_addr),
      .prog_data(prog_data), .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_we(dm_we),
      .dm_rdata(dm_rdata), .working_register(acc), .table_high(tbh),
      .program_counter(program_counter), .zero_bit(z), .carry_bit(c),
      .nibble_wrap_bit(ac), .signed_range_exceeded_bit(ov), .true_sign_bit(sc),
      .zero_with_borrow_bit(cz));
   mcalu_mem_model i_mem (.clk(clk), .prog_addr(prog_addr), .prog_data(prog_data),
      .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_rdata(dm_rdata));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [19:0] w(mcalu_op_t op, logic tm, logic im, logic [2:0] bt,
                                     logic [7:0] arg);
      return {op, tm, im, 1'b0, bt, arg};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      $display("checks=%0d errors=%0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Holds reset and clears both memories so a new program can be loaded.
   task automatic hold();
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (6) @(posedge clk);
      for (int i = 0; i < 4096; i++) i_mem.pm[i] = '0;
      for (int i = 0; i < 256; i++) i_mem.dm[i] = '0;
   endtask
   // Releases reset and runs until the program counter reaches the end address.
   task automatic go(input logic [11:0] n);
      int k;
      k = 0;
      reset_n <= 1'b1;
      @(posedge clk);
      while (program_counter !== n && k < 600) begin
         @(posedge clk);
         k++;
      end
      if (k >= 600) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, program_counter, n);
      end
      repeat (8) @(posedge clk);
   endtask
   // ----------------------------------------
   // Clock, enable and timeout
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Clock enable drops one clock in seven so that every scenario also runs stalled.
   always @(posedge clk) begin
      ce <= (cyc % 7) != 3;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         err_total++;
         test_done();
      end
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      reset_n = 1'b0;
      hold();
      i_mem.pm[0] = w(OP_MOVE, 0, 1, 0, 8'hFF);
      i_mem.pm[1] = w(OP_ADD, 0, 1, 0, 8'h01);
      go(2);
      chk({acc, 3'b0, z, c, ac, ov, sc}, 16'h001C);
      hold();
      i_mem.pm[0] = w(OP_MOVE, 0, 1, 0, 8'hFF);
      i_mem.pm[1] = w(OP_ADD, 0, 1, 0, 8'h01);
      i_mem.pm[2] = w(OP_ADC, 0, 0, 0, 8'h10);
      i_mem.pm[3] = w(OP_BCD_FIXUP, 1, 0, 0, 8'h11);
      i_mem.dm[8'h10] = 8'h7F;
      go(4);
      chk({acc, 3'b0, z, c, ac, ov, sc}, 16'h8006);
      chk(i_mem.dm[8'h11], 16'h0086);
      hold();
      i_mem.pm[0] = w(OP_MOVE, 0, 1, 0, 8'h00);
      i_mem.pm[1] = w(OP_SUB, 0, 1, 0, 8'h01);
      i_mem.pm[2] = w(OP_MINUS_WITH_WRAP, 0, 1, 0, 8'hFE);
      go(3);
      chk({acc, 3'b0, z, c, ov, sc, cz}, 16'h0018);
      hold();
      i_mem.pm[0] = w(OP_MOVE, 0, 1, 0, 8'h3C);
      for (int k = 0; k < 12; k++) begin
         i_mem.pm[k + 1] = w(ops4[k], 1, 0, (k == 9) ? 3'h7 : 3'h0, 8'h20 + k[7:0]);
         i_mem.dm[8'h20 + k] = 8'h96;
      end
      go(13);
      for (int k = 0; k < 12; k++) begin
         chk(i_mem.dm[8'h20 + k], exp4[k]);
      end
      chk({acc, 6'b0, z, c}, 16'h3C01);
      hold();
      i_mem.pm[0] = w(OP_CALL, 0, 0, 0, 8'h05);
      i_mem.pm[1] = w(OP_MOVE, 0, 1, 0, 8'h11);
      i_mem.pm[2] = w(OP_GOTO, 0, 0, 0, 8'h08);
      i_mem.pm[5] = w(OP_SUBROUTINE_EXIT, 0, 0, 0, 8'h00);
      i_mem.pm[8] = w(OP_SKIP_ZERO, 1, 0, 0, 8'h30);
      i_mem.pm[9] = w(OP_MOVE, 0, 1, 0, 8'hEE);
      i_mem.pm[10] = w(OP_TABLE_READ, 1, 0, 0, 8'h31);
      i_mem.pm[12'hF11] = 20'h0A5C3;
      go(11);
      chk({8'h00, acc}, 16'h0011);
      chk({tbh, i_mem.dm[8'h31]}, 16'hA5C3);
      chk(i_mem.dm[8'h30], 16'h0000);
      hold();
      i_mem.pm[0] = w(OP_MOVE, 0, 1, 0, 8'h04);
      i_mem.pm[1] = w(OP_MOVE, 1, 0, 0, 8'h06);
      i_mem.pm[2] = w(OP_MOVE, 0, 1, 0, 8'hEE);
      i_mem.pm[4] = w(OP_SKIP_INC_ZERO, 1, 0, 0, 8'h40);
      i_mem.pm[5] = w(OP_MOVE, 0, 1, 0, 8'hEE);
      i_mem.pm[6] = w(OP_SKIP_BIT_SET, 0, 0, 3'h1, 8'h41);
      i_mem.pm[7] = w(OP_MOVE, 0, 1, 0, 8'hEE);
      i_mem.pm[8] = w(OP_CALL, 0, 0, 0, 8'h10);
      i_mem.pm[16] = w(OP_SUBROUTINE_EXIT_IMM, 0, 1, 0, 8'h5A);
      i_mem.dm[8'h40] = 8'hFF;
      i_mem.dm[8'h41] = 8'h02;
      go(9);
      chk({8'h00, acc}, 16'h005A);
      chk(i_mem.dm[8'h40], 16'h0000);
      test_done();
   end
endmodule
`default_nettype wire

/* testbench/mcalu_mem_model.sv */
`include "mcalu_consts.svh"
`default_nettype none
module mcalu_mem_model (
   // Clock
   input wire logic clk,
   // Program memory
   input wire logic [`MCALU_PC_W-1:0] prog_addr,
   output logic [`MCALU_IW_W-1:0] prog_data,
   // Data memory, sector 0
   input wire logic [7:0] dm_addr,
   input wire logic [7:0] dm_wdata,
   input wire logic dm_we,
   output logic [7:0] dm_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [`MCALU_IW_W-1:0] pm [0:4095];
   logic [7:0] dm [0:255];
   // Both memories answer combinationally for the address presented.
   assign prog_data = pm[prog_addr];
   assign dm_rdata = dm[dm_addr];
   always @(posedge clk) begin
      if (dm_we) begin
         dm[dm_addr] <= dm_wdata;
      end
   end
endmodule
`default_nettype wire
